/* File: rtl/pm_pkg.sv */
// power-mode control constants: register map, field positions, timing
// assumes a 100 MHz system clock and byte addresses on the register bus
package pm_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int LOST_CLK_TIMEOUT_US = 100;
   // longest time, so the count rounds down
   localparam int LOST_CLK_CYCLES = (LOST_CLK_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   localparam int WDT_CYCLES_DEF = 50000; // plain default period
   localparam int RESET_HOLD_CYCLES = 4;
   localparam int CNT_W = 20;
   localparam logic [2:0] HOLD_LOAD = 3'(RESET_HOLD_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_WDT_CTRL = 8'h08;
   localparam logic [7:0] OFS_WDT_KICK = 8'h0C;
   localparam logic [7:0] OFS_LCM_CTRL = 8'h10;
   localparam logic [7:0] OFS_OSC_CTRL = 8'h14;

   // field positions
   localparam int PWR_LIGHT_BIT = 0;
   localparam int PWR_DEEP_BIT = 1;
   localparam int WDT_EN_BIT = 0;
   localparam int WDT_LOCK_BIT = 1;
   localparam int LCM_EN_BIT = 0;
   localparam int OSC_EXT_EN_BIT = 0;
   localparam int STS_LIGHT_BIT = 0;
   localparam int STS_DEEP_BIT = 1;
   localparam int STS_ARM_BIT = 2;
   localparam int STS_CAUSE_LSB = 3; // wdt, lost clock, external

   // reset values
   localparam logic [1:0] WDT_CTRL_RST = 2'h1;
   localparam logic LCM_CTRL_RST = 1'b0;
   localparam logic OSC_CTRL_RST = 1'b1;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   typedef enum logic [4:0] {
      PM_RUN = 5'b00001,
      PM_ARM = 5'b00010,
      PM_LIGHT = 5'b00100,
      PM_DEEP = 5'b01000,
      PM_RESET = 5'b10000
   } pm_state_e;

endpackage

/* File: rtl/pm_bus_if.sv */
// internal register-access carrier between the bus slave and the core
// assumes addresses arrive word aligned, low two bits forced to zero
`timescale 1ns/1ps
interface pm_bus_if;
   logic [7:0] addr;
   logic [31:0] wdat;
   logic wr_stb;
   logic [31:0] rdat;
   modport slave (output addr, output wdat, output wr_stb, input rdat);
   modport regs (input addr, input wdat, input wr_stb, output rdat);
endinterface

/* File: rtl/pm_timeout.sv */
// cycle counter that pulses once after LIMIT counted cycles
// assumes clear and reset both restart the count from zero
`timescale 1ns/1ps
module pm_timeout
   import pm_pkg::*;
#(
   parameter int unsigned LIMIT = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic clear_i,
   output logic expired_o
);
   logic [CNT_W-1:0] count_reg;

   // count only while running; saturate so the pulse is single
   always_ff @(posedge clk_i) begin
      if (rst_i || clear_i) begin
         count_reg <= '0;
         expired_o <= 1'b0;
      end else begin
         expired_o <= run_i && (count_reg == CNT_W'(LIMIT - 1));
         if (run_i && (count_reg != CNT_W'(LIMIT))) begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end
endmodule

/* File: rtl/pm_wb_slave.sv */
// classic wishbone slave front end: one wait state, registered ack
// assumes the master holds its request until it samples ack
`timescale 1ns/1ps
module pm_wb_slave
   import pm_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   pm_bus_if.slave bus
);
   logic req;

   assign req = wb_cyc_i && wb_stb_i;
   assign bus.addr = {wb_adr_i[7:2], 2'b00};
   assign bus.wdat = wb_dat_i;
   // write lands on the edge where the master sees ack
   assign bus.wr_stb = req && wb_ack_o && wb_we_i && wb_sel_i[0];

   // ack drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req && !wb_ack_o;
      end
   end

   // read data captured together with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h00000000;
      end else if (req && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= bus.rdat;
      end
   end
endmodule

/* File: rtl/pm_power_ctrl.sv */
// power-mode control for an 8-bit core: light halt, deep halt, reset paths
// assumes instr_done_i pulses when each cpu instruction completes
//
// Summary of operation
// - two modes, each entered by a bit
// - light halt stops cpu, clocks stay on
// - deep halt stops timers except clock monitor
// - light halt begins after writing instruction completes
// - light halt keeps all registers and memory
// - only enabled interrupt or reset ends light
// - interrupt wake clears light bit, restarts cpu
// - interrupt serviced first, then next instruction resumes
// - reset from light runs reset, fetch 0x0000
// - watchdog keeps counting in light, resets
// - deep bit enters deep after instruction completes
// - deep stops osc, cpu, peripherals; external untouched
// - only reset leaves deep, fetch at 0x0000
// - lost clock monitor resets out of deep
// - oscillators off needs reset to resume
// - deep select bit reads zero
// - light select bit reads zero
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module pm_power_ctrl
   import pm_pkg::*;
#(
   parameter int unsigned WDT_CYCLES = WDT_CYCLES_DEF,
   parameter int unsigned LOST_CLK_LIMIT = LOST_CLK_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic instr_done_i,
   input wire logic irq_enabled_i,
   input wire logic ext_reset_i,
   input wire logic osc_alive_i,
   output logic cpu_halt_o,
   output logic periph_run_o,
   output logic int_osc_en_o,
   output logic ext_osc_en_o,
   output logic core_reset_o,
   output logic [15:0] restart_addr_o,
   output logic irq_wake_o
);

   ////////////////////////////////////////////////////////////////////////
   // register bus front end

   pm_bus_if bus ();

   pm_wb_slave u_slave (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .bus(bus)
   );

   pm_state_e state_reg, state_next;
   logic light_sel_reg, deep_sel_reg;
   logic [2:0] hold_reg;
   logic wdt_en_reg, wdt_lock_reg, lcm_en_reg, osc_ext_en_reg;
   logic [2:0] cause_reg;
   logic wr_ok, wr_pwr, wr_wdt, wr_kick, wr_lcm, wr_osc;
   logic set_light, set_deep, go_halt;
   logic wdt_expired, lcm_expired, sys_reset_req;
   logic wdt_run, lcm_run, lcm_clear;

   // cpu is halted in deep, so bus writes then are dropped
   assign wr_ok = bus.wr_stb && (state_reg != PM_DEEP);
   assign wr_pwr = wr_ok && (bus.addr == OFS_POWER_CTRL) && (state_reg == PM_RUN);
   assign wr_wdt = wr_ok && (bus.addr == OFS_WDT_CTRL);
   assign wr_kick = wr_ok && (bus.addr == OFS_WDT_KICK);
   assign wr_lcm = wr_ok && (bus.addr == OFS_LCM_CTRL);
   assign wr_osc = wr_ok && (bus.addr == OFS_OSC_CTRL);

   // deep takes priority when both bits arrive together
   assign set_deep = wr_pwr && bus.wdat[PWR_DEEP_BIT];
   assign set_light = wr_pwr && bus.wdat[PWR_LIGHT_BIT] && !bus.wdat[PWR_DEEP_BIT];

   // a request armed earlier or written right now may take effect
   assign go_halt = light_sel_reg || deep_sel_reg || set_light || set_deep;

   // every internal source funnels into one reset sequence
   assign sys_reset_req = ext_reset_i || wdt_expired || lcm_expired;

   ////////////////////////////////////////////////////////////////////////
   // read side; select bits are write-only and always read zero

   always_comb begin
      bus.rdat = 32'h00000000;
      case (bus.addr)
         OFS_POWER_CTRL: bus.rdat = 32'h00000000;
         OFS_STATUS: begin
            bus.rdat[STS_LIGHT_BIT] = (state_reg == PM_LIGHT);
            bus.rdat[STS_DEEP_BIT] = (state_reg == PM_DEEP);
            bus.rdat[STS_ARM_BIT] = (state_reg == PM_ARM);
            bus.rdat[STS_CAUSE_LSB +: 3] = cause_reg;
         end
         OFS_WDT_CTRL: begin
            bus.rdat[WDT_EN_BIT] = wdt_en_reg;
            bus.rdat[WDT_LOCK_BIT] = wdt_lock_reg;
         end
         OFS_LCM_CTRL: bus.rdat[LCM_EN_BIT] = lcm_en_reg;
         OFS_OSC_CTRL: bus.rdat[OSC_EXT_EN_BIT] = osc_ext_en_reg;
         default: bus.rdat = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers; untouched in deep halt, where writes are dropped, but writable in light halt

   // watchdog: once locked, software can no longer switch it off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_en_reg <= WDT_CTRL_RST[WDT_EN_BIT];
         wdt_lock_reg <= WDT_CTRL_RST[WDT_LOCK_BIT];
      end else if (wr_wdt) begin
         wdt_en_reg <= bus.wdat[WDT_EN_BIT] || wdt_lock_reg;
         wdt_lock_reg <= wdt_lock_reg || bus.wdat[WDT_LOCK_BIT];
      end
   end

   // lost clock monitor enable and external oscillator enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lcm_en_reg <= LCM_CTRL_RST;
         osc_ext_en_reg <= OSC_CTRL_RST;
      end else begin
         if (wr_lcm) begin
            lcm_en_reg <= bus.wdat[LCM_EN_BIT];
         end
         if (wr_osc) begin
            osc_ext_en_reg <= bus.wdat[OSC_EXT_EN_BIT];
         end
      end
   end

   // last reset cause, loaded by each internal or external reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_reg <= 3'h0;
      end else if (sys_reset_req) begin
         cause_reg <= {ext_reset_i, lcm_expired, wdt_expired};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog and lost clock monitor

   // watchdog runs in light halt but freezes in deep halt
   assign wdt_run = wdt_en_reg && (state_reg != PM_DEEP) && (state_reg != PM_RESET);

   pm_timeout #(
      .LIMIT(WDT_CYCLES)
   ) u_wdt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(wdt_run),
      .clear_i(wr_kick || (state_reg == PM_RESET)),
      .expired_o(wdt_expired)
   );

   // monitor keeps running in deep, where osc_alive_i is ignored and cannot clear it
   assign lcm_run = lcm_en_reg && (state_reg != PM_RESET);
   assign lcm_clear = (osc_alive_i && (state_reg != PM_DEEP)) || (state_reg == PM_RESET);

   pm_timeout #(
      .LIMIT(LOST_CLK_LIMIT)
   ) u_lcm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(lcm_run),
      .clear_i(lcm_clear),
      .expired_o(lcm_expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode sequencer

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PM_RUN: begin
            if ((set_light || set_deep) && instr_done_i) begin
               state_next = set_deep ? PM_DEEP : PM_LIGHT;
            end else if (set_light || set_deep) begin
               state_next = PM_ARM;
            end
         end
         PM_ARM: begin
            // halt waits for the writing instruction to finish
            if (instr_done_i && go_halt) begin
               state_next = deep_sel_reg ? PM_DEEP : PM_LIGHT;
            end
         end
         PM_LIGHT: begin
            if (irq_enabled_i) begin
               state_next = PM_RUN;
            end
         end
         // no interrupt path: oscillator off, only reset restarts
         PM_DEEP: state_next = PM_DEEP;
         PM_RESET: begin
            if (hold_reg == 3'h0) begin
               state_next = PM_RUN;
            end
         end
         default: state_next = PM_RESET;
      endcase
      if (sys_reset_req) begin
         state_next = PM_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= PM_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // reset hold counter restarts on every reset request
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_reset_req) begin
         hold_reg <= HOLD_LOAD;
      end else if ((state_reg == PM_RESET) && (hold_reg != 3'h0)) begin
         hold_reg <= hold_reg - 1'b1;
      end
   end

   // armed select bits; interrupt wake clears the light bit
   always_ff @(posedge clk_i) begin
      if (rst_i || sys_reset_req) begin
         light_sel_reg <= 1'b0;
         deep_sel_reg <= 1'b0;
      end else if (set_light || set_deep) begin
         light_sel_reg <= set_light;
         deep_sel_reg <= set_deep;
      end else if ((state_reg == PM_LIGHT) && irq_enabled_i) begin
         light_sel_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs; the mode outputs follow the next state

   // cpu clock gated, so its registers and memory hold still
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_halt_o <= 1'b0;
         periph_run_o <= 1'b1;
         int_osc_en_o <= 1'b1;
      end else begin
         cpu_halt_o <= (state_next == PM_LIGHT) || (state_next == PM_DEEP);
         periph_run_o <= (state_next != PM_DEEP);
         int_osc_en_o <= (state_next != PM_DEEP);
      end
   end

   // external oscillator is software's alone, deep halt leaves it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_osc_en_o <= OSC_CTRL_RST;
      end else begin
         ext_osc_en_o <= wr_osc ? bus.wdat[OSC_EXT_EN_BIT] : osc_ext_en_reg;
      end
   end

   // core held in reset, then fetch starts at the reset vector
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_reset_o <= 1'b1;
         restart_addr_o <= RESET_VECTOR;
      end else begin
         core_reset_o <= (state_next == PM_RESET);
         restart_addr_o <= RESET_VECTOR;
      end
   end

   // wake pulse: interrupt logic vectors first; the pc is untouched,
   // so the return lands on the instruction after the halting write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_wake_o <= 1'b0;
      end else begin
         irq_wake_o <= (state_reg == PM_LIGHT) && (state_next == PM_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_light_wake;
      (state_reg == PM_LIGHT) && irq_enabled_i && !sys_reset_req;
   endsequence

   sequence s_woke;
      (state_reg == PM_RUN) && irq_wake_o && !light_sel_reg;
   endsequence

   sequence s_reset_ends;
      core_reset_o ##1 !core_reset_o;
   endsequence

   a_light_wake_clear: assert property (s_light_wake |=> s_woke)
      else $error("interrupt did not end light halt cleanly");
   a_light_hold_on: assert property ((state_reg == PM_LIGHT) && !irq_enabled_i
      && !sys_reset_req |=> (state_reg == PM_LIGHT) && cpu_halt_o)
      else $error("light halt left without a cause");
   a_halt_after_done: assert property ((state_reg == PM_ARM) && instr_done_i
      && light_sel_reg && !sys_reset_req |=> (state_reg == PM_LIGHT) ##1 cpu_halt_o)
      else $error("light halt not entered after instruction end");
   a_deep_priority: assert property (wr_pwr && (bus.wdat[1:0] == 2'h3) && !sys_reset_req
      |=> deep_sel_reg && !light_sel_reg)
      else $error("deep select lost to light select");
   a_deep_stays: assert property ((state_reg == PM_DEEP) && !sys_reset_req
      |=> (state_reg == PM_DEEP) [*2] or (state_reg == PM_DEEP) ##1 core_reset_o)
      else $error("deep halt left without reset");
   a_deep_clocks_off: assert property ((state_reg == PM_DEEP) |-> !int_osc_en_o
      && !periph_run_o && cpu_halt_o && !wdt_run)
      else $error("clocks still running in deep halt");
   a_light_periph_on: assert property ((state_reg == PM_LIGHT) |-> periph_run_o
      && int_osc_en_o && cpu_halt_o)
      else $error("light halt stopped peripherals");
   a_wdt_ends_light: assert property (wdt_expired && (state_reg == PM_LIGHT)
      |=> (state_reg == PM_RESET) && core_reset_o)
      else $error("watchdog did not end light halt");
   a_lcm_ends_deep: assert property (lcm_expired && (state_reg == PM_DEEP)
      |=> core_reset_o ##[1:8] (state_reg == PM_RUN))
      else $error("lost clock reset did not restart core");
   a_reset_vector: assert property (s_reset_ends |-> restart_addr_o == RESET_VECTOR
      && !cpu_halt_o && (state_reg == PM_RUN))
      else $error("core restarted away from reset vector");
   a_select_reads_zero: assert property (wb_ack_o && !wb_we_i
      && ($past(bus.addr) == OFS_POWER_CTRL) |-> (wb_dat_o[1:0] == 2'h0))
      else $error("select bits read back non-zero");

endmodule

/* File: verification/pm_cpu_model.sv */
// stand-in for the cpu core, interrupt logic and reset sources around the power block
// assumes the bench steers it through its request inputs on the one system clock
`timescale 1ns/1ps
module pm_cpu_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] gap_i,
   input wire logic irq_req_i,
   input wire logic ext_rst_req_i,
   input wire logic cpu_halt_i,
   input wire logic int_osc_en_i,
   input wire logic irq_wake_i,
   input wire logic core_reset_i,
   output logic instr_done_o,
   output logic irq_enabled_o,
   output logic ext_reset_o,
   output logic osc_alive_o
);
   logic [3:0] gap_cnt_reg;
   logic [1:0] osc_cnt_reg;

   ////////////////////////////////////////////////////////////////////////
   // instruction completions; gap 0 stalls the core mid-instruction
   always_ff @(posedge clk_i) begin
      if (rst_i || cpu_halt_i || core_reset_i || gap_i == 4'h0) begin
         gap_cnt_reg <= 4'h0;
         instr_done_o <= 1'b0;
      end else if (gap_cnt_reg >= gap_i - 4'h1) begin
         gap_cnt_reg <= 4'h0;
         instr_done_o <= 1'b1;
      end else begin
         gap_cnt_reg <= gap_cnt_reg + 4'h1;
         instr_done_o <= 1'b0;
      end
   end

   // pending interrupt held until serviced; a reset throws it away
   always_ff @(posedge clk_i) begin
      if (rst_i || core_reset_i || irq_wake_i) begin
         irq_enabled_o <= 1'b0;
      end else if (irq_req_i) begin
         irq_enabled_o <= 1'b1;
      end
   end

   // reset source and oscillator edges; no edges once the oscillator stops
   always_ff @(posedge clk_i) begin
      ext_reset_o <= ext_rst_req_i && !rst_i;
      osc_cnt_reg <= rst_i ? 2'h0 : osc_cnt_reg + 2'h1;
      osc_alive_o <= int_osc_en_i && osc_cnt_reg == 2'h3;
   end
endmodule

/* File: verification/pm_power_ctrl_tb_top.sv */
// self-checking bench for the power-mode block: wishbone master, queue-based read checks
// assumes pm_cpu_model plays the core side; shortened watchdog and clock-monitor counts
`timescale 1ns/1ps
module pm_power_ctrl_tb_top;
   import pm_pkg::*;
   localparam int WDT_SIM = 40;
   localparam int LCM_SIM = 30;
   localparam int CYC_LIMIT = 20000;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic instr_done, irq_enabled, ext_reset, osc_alive, irq_wake_o, core_reset_o;
   logic cpu_halt_o, periph_run_o, int_osc_en_o, ext_osc_en_o;
   logic [15:0] restart_addr_o;
   logic [3:0] gap = 4'h1;
   logic irq_req = 1'b0, ext_req = 1'b0;
   logic [31:0] exp_q[$];
   logic [7:0] adr_q[$];
   int failures = 0, checked = 0, cycles = 0, seed = 89;
   bit h;

   ////////////////////////////////////////////////////////////////////////
   pm_power_ctrl #(.WDT_CYCLES(WDT_SIM), .LOST_CLK_LIMIT(LCM_SIM)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_done_i(instr_done),
      .irq_enabled_i(irq_enabled), .ext_reset_i(ext_reset), .osc_alive_i(osc_alive),
      .cpu_halt_o(cpu_halt_o), .periph_run_o(periph_run_o), .int_osc_en_o(int_osc_en_o),
      .ext_osc_en_o(ext_osc_en_o), .core_reset_o(core_reset_o),
      .restart_addr_o(restart_addr_o), .irq_wake_o(irq_wake_o));
   pm_cpu_model u_cpu (
      .clk_i(clk_i), .rst_i(rst_i), .gap_i(gap), .irq_req_i(irq_req),
      .ext_rst_req_i(ext_req), .cpu_halt_i(cpu_halt_o), .int_osc_en_i(int_osc_en_o),
      .irq_wake_i(irq_wake_o), .core_reset_i(core_reset_o), .instr_done_o(instr_done),
      .irq_enabled_o(irq_enabled), .ext_reset_o(ext_reset), .osc_alive_o(osc_alive));

   ////////////////////////////////////////////////////////////////////////
   // 100 MHz clock and a hang guard
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == CYC_LIMIT) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // read data checked at the ack edge against the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
         if (exp_q.size() == 0) chk("unexpected read", 32'h0, 32'hFFFFFFFF);
         else chk($sformatf("read %h", adr_q.pop_front()), exp_q.pop_front(), wb_dat_o);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // classic single cycle: request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      if (!w) exp_q.push_back(e);
      if (!w) adr_q.push_back(a);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      // a hang here is ended by the cycle ceiling; one wait state expected
      chk("wb_ack_o latency", 32'h2, 32'(n));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF, e);
   endtask

   // bounded wait on one of the mode outputs, sampled at each rising edge
   function automatic logic pick(input int w);
      case (w)
         0: return cpu_halt_o;
         1: return core_reset_o;
         default: return irq_wake_o;
      endcase
   endfunction
   task automatic wait_sig(input int w, input logic v, input int lim, output bit hit);
      hit = 0;
      for (int n = 0; n < lim && !hit; n++) begin
         @(posedge clk_i);
         hit = (pick(w) === v);
      end
   endtask
   task automatic enter(input logic [31:0] v);
      wr(OFS_POWER_CTRL, v);
      wait_sig(0, 1'b1, 30, h);
      chk("cpu_halt_o entry", 32'h1, 32'(h));
   endtask
   task automatic pulse(input bit ext);
      @(posedge clk_i);
      if (ext) ext_req <= 1'b1;
      else irq_req <= 1'b1;
      @(posedge clk_i);
      {ext_req, irq_req} <= 2'b00;
   endtask
   // reset pulse seen, then the core restarts running from the reset vector
   task automatic wait_reset(input int lim, input logic [31:0] cause);
      wait_sig(1, 1'b1, lim, h);
      chk("core_reset_o rise", 32'h1, 32'(h));
      wait_sig(1, 1'b0, 12, h);
      chk("core_reset_o fall", 32'h1, 32'(h));
      chk("restart_addr_o", 32'(RESET_VECTOR), 32'(restart_addr_o));
      chk("cpu_halt_o after reset", 32'h0, 32'(cpu_halt_o));
      chk("int_osc_en_o after reset", 32'h1, 32'(int_osc_en_o));
      chk("periph_run_o after reset", 32'h1, 32'(periph_run_o));
      rd(OFS_STATUS, cause << STS_CAUSE_LSB);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_sig(1, 1'b0, 12, h);
      chk("power-on release", 32'h1, 32'(h));
      wr(OFS_WDT_CTRL, 32'h0);
      wb(1'b1, OFS_WDT_CTRL, 32'h1, 4'hE, 32'h0);
      rd(OFS_WDT_CTRL, 32'h0);
      wr(8'h18, $random(seed));
      rd(8'h18, 32'h0);
      rd(OFS_LCM_CTRL, 32'(LCM_CTRL_RST));
      rd(OFS_OSC_CTRL, 32'(OSC_CTRL_RST));
      $display("test registers finished");
      // light halt waits for the writing instruction to finish
      gap <= 4'h0;
      wr(OFS_POWER_CTRL, 32'h1);
      repeat (8) @(posedge clk_i);
      chk("cpu_halt_o while armed", 32'h0, 32'(cpu_halt_o));
      rd(OFS_STATUS, 32'h1 << STS_ARM_BIT);
      gap <= 4'(($random(seed) & 7) + 1);
      wait_sig(0, 1'b1, 30, h);
      chk("cpu_halt_o light", 32'h1, 32'(h));
      chk("periph_run_o light", 32'h1, 32'(periph_run_o));
      chk("int_osc_en_o light", 32'h1, 32'(int_osc_en_o));
      rd(OFS_POWER_CTRL, 32'h0);
      wr(OFS_POWER_CTRL, 32'h2);
      wait_sig(0, 1'b0, 20, h);
      chk("light held", 32'h0, 32'(h));
      chk("int_osc_en_o held", 32'h1, 32'(int_osc_en_o));
      pulse(1'b0);
      wait_sig(2, 1'b1, 8, h);
      chk("irq_wake_o", 32'h1, 32'(h));
      chk("cpu_halt_o wake", 32'h0, 32'(cpu_halt_o));
      chk("core_reset_o wake", 32'h0, 32'(core_reset_o));
      rd(OFS_STATUS, 32'h0);
      rd(OFS_WDT_CTRL, 32'h0);
      rd(OFS_OSC_CTRL, 32'h1);
      $display("test light wake finished");
      // light halt ended by the external reset
      enter(32'h1);
      pulse(1'b1);
      wait_reset(8, 32'h4);
      rd(OFS_WDT_CTRL, 32'h0);
      $display("test light reset finished");
      // watchdog keeps counting through light halt
      wr(OFS_WDT_CTRL, 32'h1);
      wr(OFS_WDT_KICK, 32'h0);
      enter(32'h1);
      wait_reset(WDT_SIM + 20, 32'h1);
      wr(OFS_WDT_CTRL, 32'h0);
      $display("test watchdog finished");
      // deep halt: both bits, deep wins; external oscillator left alone
      wr(OFS_OSC_CTRL, 32'h0);
      repeat (2) @(posedge clk_i);
      chk("ext_osc_en_o off", 32'h0, 32'(ext_osc_en_o));
      wr(OFS_OSC_CTRL, 32'h1);
      enter(32'h3);
      chk("int_osc_en_o deep", 32'h0, 32'(int_osc_en_o));
      chk("periph_run_o deep", 32'h0, 32'(periph_run_o));
      chk("ext_osc_en_o deep", 32'h1, 32'(ext_osc_en_o));
      pulse(1'b0);
      wr(OFS_OSC_CTRL, 32'h0);
      wait_sig(2, 1'b1, 40, h);
      chk("irq_wake_o in deep", 32'h0, 32'(h));
      chk("cpu_halt_o deep held", 32'h1, 32'(cpu_halt_o));
      chk("ext_osc_en_o kept", 32'h1, 32'(ext_osc_en_o));
      pulse(1'b1);
      wait_reset(8, 32'h4);
      rd(OFS_POWER_CTRL, 32'h0);
      $display("test deep finished");
      // lost clock monitor pulls the core out of deep halt
      wr(OFS_LCM_CTRL, 32'h1);
      enter(32'h2);
      wait_reset(LCM_SIM + 20, 32'h2);
      wr(OFS_LCM_CTRL, 32'h0);
      $display("test lost clock finished");
      print_verdict();
   end
endmodule
